// >>> logic/ltc_pkg.sv
// Package of constants and types for the LIN transceiver control block
package ltc_pkg;
  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_MHZ = 100;
  localparam int FAULT_VALID_US = 25;
  localparam int FAULT_VALID_CYC = FAULT_VALID_US * CLK_MHZ;
  localparam int REG_RETRY_MS = 3;
  localparam int REG_RETRY_CYC = REG_RETRY_MS * 1000 * CLK_MHZ;
  localparam int REG_STABLE_US = 10;
  localparam int REG_STABLE_CYC = REG_STABLE_US * CLK_MHZ;
  localparam int DOM_TIMEOUT_US = 10000;
  localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * CLK_MHZ;

  // ==========================================================================
  // Operating modes
  // ==========================================================================
  typedef enum logic [2:0] {
    LTC_POR,
    LTC_READY,
    LTC_OPERATION,
    LTC_TRANSMITTER_OFF_MODE,
    LTC_POWER_DOWN
  } ltc_mode_type;
endpackage

// >>> logic/ltc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ltc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;
  logic s2_r;
  logic s3_r;

  // ==========================================================================
  // Capture chain
  // ==========================================================================
  // First stage is read only by the second stage
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      meta_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      s2_r <= meta_r;
      s3_r <= s2_r;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync_out <= RESET_VAL;
    end else if (s2_r == s3_r) begin
      sync_out <= s3_r;
    end
  end
endmodule
`default_nettype wire

// >>> logic/ltc_core.sv
// LIN transceiver control: bus drive, fault reporting and mode sequencing
// Summary of operation
// - Bus pulled dominant while transmit data low, released recessive while high.
// - Transmit data forced high while regulator output below about 1.8 V.
// - Over-temperature with transmit low shuts transmitter until cooled.
// - Receive output continuously follows the sensed bus level.
// - Transmitter stays disabled unless select_wake is high.
// - Select_wake low at power-up leaves device in Ready, driver off.
// - Select_wake high at power-up advances only after regulator stabilised.
// - Externally raised select_wake acts as a local wake-up.
// - Driver disabled whenever fault_txen is low; regulator keeps running.
// - Transmit versus bus compare is debounced and reported on fault_txen.
// - Fault_txen pulled low after short or thermal fault disables driver.
// - Fault_txen pulled low and driver off while regulator output invalid.
// - Only transmit low with bus recessive reports a mismatch fault.
// - Thermal shutdown pulls fault_txen low whatever the data levels.
// - Mismatch fault valid about 25 us after a transmit falling edge.
// - Reset output released while supply valid, pulled low when it fails.
// - Reset output asserted immediately on entering Power-Down.
// - Regulator stays off after low battery until battery above 5.75 V.
// - Overloaded regulator below 3.5 V turns off, retried after about 3 ms.
// - Over-temperature stops regulator unless transmit low with receive high.
// - Ready with select_wake high goes to Operation or Transmitter-Off.
// - Operation goes Power-Down on select_wake low, Transmitter-Off on fault.
// - Transmitter-Off returns to Operation or goes to Power-Down.
// - Power-Down wakes to Ready on falling bus edge or select_wake.
`timescale 1ns/1ps
`default_nettype none
module ltc_core #(
  parameter int FAULT_VALID_CYC = ltc_pkg::FAULT_VALID_CYC,
  parameter int REG_RETRY_CYC = ltc_pkg::REG_RETRY_CYC,
  parameter int REG_STABLE_CYC = ltc_pkg::REG_STABLE_CYC,
  parameter int DOM_TIMEOUT_CYC = ltc_pkg::DOM_TIMEOUT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic tx_in,
  input wire logic select_wake_in,
  input wire logic bus_line_in,
  input wire logic fault_txen_in,
  input wire logic vbb_ok_in,
  input wire logic vreg_min_in,
  input wire logic vreg_ok_in,
  input wire logic over_temp_in,
  output logic bus_line_out,
  output logic bus_line_oe_out,
  output logic rx_out,
  output logic fault_txen_out,
  output logic fault_txen_oe_out,
  output logic rst_out_n_out,
  output logic rst_out_n_oe_out,
  output logic reg_on_out,
  output ltc_pkg::ltc_mode_type mode_out
);
  localparam int CW = 32;

  // ==========================================================================
  // Input synchronisation
  // ==========================================================================
  logic tx_s;
  logic cs_s;
  logic bus_s;
  logic ftx_s;
  logic vbb_s;
  logic vmin_s;
  logic vok_s;
  logic ot_s;

  ltc_sync #(.RESET_VAL(1'b1)) u_tx (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .async_in(tx_in), .sync_out(tx_s));
  ltc_sync #(.RESET_VAL(1'b0)) u_cs (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .async_in(select_wake_in), .sync_out(cs_s));
  ltc_sync #(.RESET_VAL(1'b1)) u_bus (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .async_in(bus_line_in), .sync_out(bus_s));
  ltc_sync #(.RESET_VAL(1'b1)) u_ftx (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .async_in(fault_txen_in), .sync_out(ftx_s));
  ltc_sync #(.RESET_VAL(1'b0)) u_vbb (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .async_in(vbb_ok_in), .sync_out(vbb_s));
  ltc_sync #(.RESET_VAL(1'b0)) u_vmin (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .async_in(vreg_min_in), .sync_out(vmin_s));
  ltc_sync #(.RESET_VAL(1'b0)) u_vok (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .async_in(vreg_ok_in), .sync_out(vok_s));
  ltc_sync #(.RESET_VAL(1'b0)) u_ot (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .async_in(over_temp_in), .sync_out(ot_s));

  // ==========================================================================
  // State
  // ==========================================================================
  ltc_pkg::ltc_mode_type mode_r;
  ltc_pkg::ltc_mode_type mode_nxt;
  logic tx_eff;
  logic tx_prev_r;
  logic [CW-1:0] deb_cnt_r;
  logic mismatch_r;
  logic therm_tx_off_r;
  logic therm_reg_off_r;
  logic reg_on_r;
  logic [CW-1:0] retry_cnt_r;
  logic retry_r;
  logic [CW-1:0] stable_cnt_r;
  logic stable_r;
  logic was_up_r;
  logic [CW-1:0] dom_cnt_r;
  logic perm_dom_r;
  logic bus_prev_r;
  logic int_fault;
  logic ext_low;
  logic drv_en;

  // Saturating increment used by all timers
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v, input int lim);
    sat_inc = (v >= CW'(lim)) ? v : v + 1'b1;
  endfunction

  // Regulator too low to trust the data pin forces recessive
  assign tx_eff = vmin_s ? tx_s : 1'b1;

  // ==========================================================================
  // Mismatch compare
  // ==========================================================================
  // Debounce restarts on every falling edge so propagation delay is not a fault
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tx_prev_r <= 1'b1;
      deb_cnt_r <= '0;
      mismatch_r <= 1'b0;
    end else begin
      tx_prev_r <= tx_eff;
      if (tx_eff || (tx_prev_r && !tx_eff)) begin
        deb_cnt_r <= '0;
      end else begin
        deb_cnt_r <= sat_inc(deb_cnt_r, FAULT_VALID_CYC);
      end
      // Only low data with a recessive bus is a mismatch; once set it holds while
      // that pair stands, else dropping the driver would clear it and oscillate
      mismatch_r <= !tx_eff && bus_s && !ext_low && (mismatch_r
        || (drv_en && deb_cnt_r >= CW'(FAULT_VALID_CYC - 1)));
    end
  end

  // ==========================================================================
  // Thermal protection
  // ==========================================================================
  // Transmitter or regulator goes off depending on data levels while over-temperature lasts
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      therm_tx_off_r <= 1'b0;
      therm_reg_off_r <= 1'b0;
    end else if (!ot_s) begin
      therm_tx_off_r <= 1'b0;
      therm_reg_off_r <= 1'b0;
    end else begin
      if (!tx_eff) begin
        therm_tx_off_r <= 1'b1;
      end
      if (tx_eff || !bus_s) begin
        therm_reg_off_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Regulator control
  // ==========================================================================
  // Battery monitor gates restart; overload retried after a fixed wait
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_on_r <= 1'b0;
      retry_r <= 1'b0;
      retry_cnt_r <= '0;
    end else begin
      if (retry_r) begin
        retry_cnt_r <= sat_inc(retry_cnt_r, REG_RETRY_CYC);
      end
      if (mode_r == ltc_pkg::LTC_POR || mode_r == ltc_pkg::LTC_POWER_DOWN
          || therm_reg_off_r) begin
        reg_on_r <= 1'b0;
      end else if (retry_r) begin
        if (retry_cnt_r >= CW'(REG_RETRY_CYC - 1)) begin
          retry_r <= 1'b0;
          reg_on_r <= vbb_s;
        end
      end else if (reg_on_r && was_up_r && !vmin_s && vbb_s) begin
        reg_on_r <= 1'b0;
        retry_r <= 1'b1;
        retry_cnt_r <= '0;
      end else if (!reg_on_r && vbb_s) begin
        reg_on_r <= 1'b1;
      end else if (!vbb_s && reg_on_r && !vmin_s) begin
        reg_on_r <= 1'b0;
      end
    end
  end

  // Output must stay good for a settling time before it counts as stable
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      stable_cnt_r <= '0;
      stable_r <= 1'b0;
    end else if (!reg_on_r || !vok_s) begin
      stable_cnt_r <= '0;
      stable_r <= 1'b0;
    end else begin
      stable_cnt_r <= sat_inc(stable_cnt_r, REG_STABLE_CYC);
      stable_r <= stable_cnt_r >= CW'(REG_STABLE_CYC - 1);
    end
  end

  // Overload check arms once the output has been good, so start-up is no short
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !reg_on_r) begin
      was_up_r <= 1'b0;
    end else if (stable_r) begin
      was_up_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Permanent dominant and wake edge
  // ==========================================================================
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dom_cnt_r <= '0;
      perm_dom_r <= 1'b0;
      bus_prev_r <= 1'b1;
    end else begin
      bus_prev_r <= bus_s;
      if (bus_s || mode_r != ltc_pkg::LTC_OPERATION) begin
        dom_cnt_r <= '0;
        perm_dom_r <= 1'b0;
      end else begin
        dom_cnt_r <= sat_inc(dom_cnt_r, DOM_TIMEOUT_CYC);
        perm_dom_r <= dom_cnt_r >= CW'(DOM_TIMEOUT_CYC - 1);
      end
    end
  end

  // ==========================================================================
  // Mode sequencing
  // ==========================================================================
  // External low on the shared line is told apart from our own pull-down
  assign int_fault = mismatch_r || therm_tx_off_r || ot_s || !stable_r;
  assign ext_low = !ftx_s && !fault_txen_oe_out;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      ltc_pkg::LTC_POR: begin
        if (vbb_s) begin
          mode_nxt = ltc_pkg::LTC_READY;
        end
      end
      ltc_pkg::LTC_READY: begin
        if (cs_s && stable_r) begin
          mode_nxt = ftx_s ? ltc_pkg::LTC_OPERATION
            : ltc_pkg::LTC_TRANSMITTER_OFF_MODE;
        end
      end
      ltc_pkg::LTC_OPERATION: begin
        if (!cs_s) begin
          mode_nxt = ltc_pkg::LTC_POWER_DOWN;
        end else if (!ftx_s || perm_dom_r) begin
          mode_nxt = ltc_pkg::LTC_TRANSMITTER_OFF_MODE;
        end
      end
      ltc_pkg::LTC_TRANSMITTER_OFF_MODE: begin
        if (!cs_s) begin
          mode_nxt = ltc_pkg::LTC_POWER_DOWN;
        end else if (ftx_s) begin
          mode_nxt = ltc_pkg::LTC_OPERATION;
        end
      end
      ltc_pkg::LTC_POWER_DOWN: begin
        if ((bus_prev_r && !bus_s) || cs_s) begin
          mode_nxt = ltc_pkg::LTC_READY;
        end
      end
      default: mode_nxt = ltc_pkg::LTC_POR;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mode_r <= ltc_pkg::LTC_POR;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Driver needs Operation, select high, line high, no thermal lockout and a stable regulator
  assign drv_en = (mode_r == ltc_pkg::LTC_OPERATION) && cs_s && ftx_s
    && !therm_tx_off_r && stable_r;

  // ==========================================================================
  // Pin outputs
  // ==========================================================================
  // Registered pins; open-drain pins only ever drive low
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bus_line_out <= 1'b0;
      bus_line_oe_out <= 1'b0;
      rx_out <= 1'b1;
      fault_txen_out <= 1'b0;
      fault_txen_oe_out <= 1'b0;
      rst_out_n_out <= 1'b0;
      rst_out_n_oe_out <= 1'b1;
      reg_on_out <= 1'b0;
      mode_out <= ltc_pkg::LTC_POR;
    end else begin
      bus_line_out <= 1'b0;
      bus_line_oe_out <= drv_en && !tx_eff;
      rx_out <= bus_s;
      fault_txen_out <= 1'b0;
      fault_txen_oe_out <= int_fault && !(ext_low && !mismatch_r);
      rst_out_n_out <= 1'b0;
      rst_out_n_oe_out <= !stable_r || mode_nxt == ltc_pkg::LTC_POWER_DOWN;
      reg_on_out <= reg_on_r;
      mode_out <= mode_r;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_tx_dom;
    @(posedge sys_clk_in) disable iff (rst_in)
      bus_line_oe_out |-> $past(tx_eff) == 1'b0;
  endproperty
  a_tx_dom: assert property (p_tx_dom) else $error("Bus driven while tx high");

  property p_rx_follow;
    @(posedge sys_clk_in) disable iff (rst_in) ##1 rx_out == $past(bus_s);
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("Rx not following bus");

  property p_cs_off;
    @(posedge sys_clk_in) disable iff (rst_in)
      !cs_s |=> !bus_line_oe_out;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("Driver on with select low");

  property p_ftx_off;
    @(posedge sys_clk_in) disable iff (rst_in)
      !ftx_s |=> !bus_line_oe_out;
  endproperty
  a_ftx_off: assert property (p_ftx_off) else $error("Driver on with fault line low");

  property p_therm_flag;
    @(posedge sys_clk_in) disable iff (rst_in)
      (ot_s && !ext_low) |=> fault_txen_oe_out;
  endproperty
  a_therm_flag: assert property (p_therm_flag) else $error("Thermal not flagged");

  property p_deb;
    @(posedge sys_clk_in) disable iff (rst_in)
      (tx_prev_r && !tx_eff) |=> !mismatch_r [*2];
  endproperty
  a_deb: assert property (p_deb) else $error("Mismatch not debounced");

  property p_pd_rst;
    @(posedge sys_clk_in) disable iff (rst_in)
      (mode_r == ltc_pkg::LTC_POWER_DOWN) |-> rst_out_n_oe_out;
  endproperty
  a_pd_rst: assert property (p_pd_rst) else $error("Reset not held in power-down");

  property p_ready_go;
    @(posedge sys_clk_in) disable iff (rst_in)
      (mode_r == ltc_pkg::LTC_READY && cs_s && stable_r && ftx_s)
        |=> mode_r == ltc_pkg::LTC_OPERATION;
  endproperty
  a_ready_go: assert property (p_ready_go) else $error("Ready did not enter operation");

  property p_op_pd;
    @(posedge sys_clk_in) disable iff (rst_in)
      (mode_r == ltc_pkg::LTC_OPERATION && !cs_s) |=> mode_r == ltc_pkg::LTC_POWER_DOWN;
  endproperty
  a_op_pd: assert property (p_op_pd) else $error("Operation did not power down");
endmodule
`default_nettype wire

// >>> tb/ltc_mcu_model.sv
// Controller-side model: transmit data, select drive and fault line sampling
`timescale 1ns/1ps
`default_nettype none
module ltc_mcu_model #(
  parameter int IGNORE_CYC = 25
) (
  input wire logic sys_clk_in,
  input wire logic fault_txen_in,
  output logic tx_out,
  output logic sel_out,
  output logic sel_oe_out,
  output logic fault_low_out,
  output logic fault_seen_out
);
  int since_fall_r = 0;
  logic tx_prev_r = 1'b1;

  // ==========================================================================
  // Pin drivers, changed just after a falling clock edge by the bench
  // ==========================================================================
  initial begin
    tx_out = 1'b1;
    sel_out = 1'b0;
    sel_oe_out = 1'b1;
    fault_low_out = 1'b0;
  end

  task automatic set_tx(input logic v);
    tx_out = v;
  endtask

  // Releasing the pin leaves it to the pull-down or an outside wake source
  task automatic set_sel(input logic drive, input logic v);
    sel_oe_out = drive;
    sel_out = v;
  endtask

  // Low on the shared line commands the transmitter off
  task automatic set_fault_low(input logic v);
    fault_low_out = v;
  endtask

  // ==========================================================================
  // Fault sampler
  // ==========================================================================
  // Sampled every cycle, far inside the 10 us limit; readings just after a
  // transmit fall are ignored because bus delay makes them meaningless
  always @(posedge sys_clk_in) begin
    tx_prev_r <= tx_out;
    if (tx_prev_r && !tx_out) begin
      since_fall_r <= 0;
    end else if (since_fall_r < IGNORE_CYC) begin
      since_fall_r <= since_fall_r + 1;
    end
    fault_seen_out <= (since_fall_r >= IGNORE_CYC) && !fault_txen_in;
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench for the LIN transceiver control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int FV = 20;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vbb_ok = 1'b0;
  logic vreg_min = 1'b0;
  logic vreg_ok = 1'b0;
  logic hot = 1'b0;
  logic short_vbb = 1'b0;
  logic ext_dom = 1'b0;
  logic ext_wake = 1'b0;
  wire logic tx, sel_d, sel_oe, f_low, f_seen, bus_oe, f_oe, r_oe, reg_on, rx;
  wire logic bus_o, f_o, r_o, bus_w, sel_w, fault_w;
  ltc_pkg::ltc_mode_type mode;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  // ==========================================================================
  // Wires: bus pulled up, select pulled down, fault line pulled up
  // ==========================================================================
  assign bus_w = short_vbb | ~(ext_dom | (bus_oe & ~bus_o));
  assign sel_w = sel_oe ? sel_d : ext_wake;
  assign fault_w = ~(f_low | (f_oe & ~f_o));

  ltc_mcu_model #(.IGNORE_CYC(FV + 8)) mcu_u (.sys_clk_in(clk), .fault_txen_in(fault_w),
    .tx_out(tx), .sel_out(sel_d), .sel_oe_out(sel_oe), .fault_low_out(f_low),
    .fault_seen_out(f_seen));

  ltc_core #(.FAULT_VALID_CYC(FV), .REG_RETRY_CYC(50), .REG_STABLE_CYC(10),
    .DOM_TIMEOUT_CYC(100)) dut_u (.sys_clk_in(clk), .rst_in(rst), .tx_in(tx),
    .select_wake_in(sel_w), .bus_line_in(bus_w), .fault_txen_in(fault_w),
    .vbb_ok_in(vbb_ok), .vreg_min_in(vreg_min), .vreg_ok_in(vreg_ok),
    .over_temp_in(hot), .bus_line_out(bus_o), .bus_line_oe_out(bus_oe), .rx_out(rx),
    .fault_txen_out(f_o), .fault_txen_oe_out(f_oe), .rst_out_n_out(r_o),
    .rst_out_n_oe_out(r_oe), .reg_on_out(reg_on), .mode_out(mode));

  // ==========================================================================
  // Clock, watchdog and reporting
  // ==========================================================================
  always #5 clk = ~clk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A hang anywhere ends the run as a failure rather than stalling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      $display("BAD %0t watchdog expired", $time);
      n_fail = n_fail + 1;
      close_out();
    end
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_mode(input ltc_pkg::ltc_mode_type exp, input string what);
    n_checks = n_checks + 1;
    if (mode !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %0t %s mode %0d exp %0d", $time, what, mode, exp);
    end
  endtask

  // Bounded polls; inputs cross three sync stages so answers lag a few cycles
  task automatic wait_mode(input ltc_pkg::ltc_mode_type exp, input int max, input string what);
    for (int i = 0; i < max && mode !== exp; i++) @(negedge clk);
    chk_mode(exp, what);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    settle(20);
    chk_mode(ltc_pkg::LTC_POR, "reset mode");
    chk_bit(r_oe, 1'b1, "reset out in reset");
    chk_bit(bus_oe | f_oe | reg_on, 1'b0, "drivers in reset");
    chk_bit(rx, 1'b1, "rx in reset");
    chk_bit(bus_o | f_o | r_o, 1'b0, "open drain levels");
    rst = 1'b0;
  endtask

  // Select low at power-up: stays in Ready, driver off even with data low
  task automatic t_ready;
    vbb_ok = 1'b1;
    vreg_min = 1'b1;
    vreg_ok = 1'b1;
    wait_mode(ltc_pkg::LTC_READY, 40, "power up");
    ext_dom = 1'b1;
    mcu_u.set_tx(1'b0);
    settle(40);
    chk_mode(ltc_pkg::LTC_READY, "select low");
    chk_bit(bus_oe, 1'b0, "driver while deselected");
    chk_bit(rx, 1'b0, "rx dominant");
    chk_bit(reg_on, 1'b1, "regulator in ready");
    chk_bit(r_oe, 1'b0, "reset out released");
    mcu_u.set_tx(1'b1);
    ext_dom = 1'b0;
    settle(10);
  endtask

  // Outside wake source raises the released select pin
  task automatic t_wake;
    mcu_u.set_sel(1'b0, 1'b0);
    ext_wake = 1'b1;
    wait_mode(ltc_pkg::LTC_OPERATION, 60, "local wake");
    mcu_u.set_sel(1'b1, 1'b1);
    ext_wake = 1'b0;
  endtask

  task automatic t_drive;
    mcu_u.set_tx(1'b0);
    settle(10);
    chk_bit(bus_oe, 1'b1, "dominant drive");
    chk_bit(rx, 1'b0, "rx follows low");
    settle(40);
    chk_bit(f_oe, 1'b0, "low data low bus");
    mcu_u.set_tx(1'b1);
    ext_dom = 1'b1;
    settle(10);
    chk_bit(bus_oe, 1'b0, "recessive release");
    chk_bit(f_oe | rx, 1'b0, "receiving from bus");
    ext_dom = 1'b0;
    settle(10);
    chk_bit(rx, 1'b1, "rx follows high");
    // Bus held dominant by someone else past the timeout
    ext_dom = 1'b1;
    wait_mode(ltc_pkg::LTC_TRANSMITTER_OFF_MODE, 150, "permanent dominant");
    ext_dom = 1'b0;
    wait_mode(ltc_pkg::LTC_OPERATION, 20, "dominant cleared");
  endtask

  // Bus held at battery while sending low: debounced fault, then recovery
  task automatic t_mismatch;
    short_vbb = 1'b1;
    mcu_u.set_tx(1'b0);
    settle(12);
    chk_bit(f_oe, 1'b0, "fault before debounce");
    chk_bit(f_seen, 1'b0, "controller quiet early");
    settle(30);
    chk_bit(f_oe, 1'b1, "short fault");
    chk_bit(f_seen, 1'b1, "controller saw fault");
    chk_bit(bus_oe, 1'b0, "driver off on fault");
    chk_mode(ltc_pkg::LTC_TRANSMITTER_OFF_MODE, "fault to tx off");
    mcu_u.set_tx(1'b1);
    short_vbb = 1'b0;
    wait_mode(ltc_pkg::LTC_OPERATION, 60, "fault cleared");
  endtask

  // Controller pulls the fault line low: transmitter off, no fault reported
  task automatic t_ext_off;
    mcu_u.set_fault_low(1'b1);
    mcu_u.set_tx(1'b0);
    wait_mode(ltc_pkg::LTC_TRANSMITTER_OFF_MODE, 20, "commanded off");
    settle(40);
    chk_bit(bus_oe, 1'b0, "driver off by command");
    chk_bit(f_oe, 1'b0, "no fault on command");
    chk_bit(reg_on, 1'b1, "regulator keeps running");
    mcu_u.set_tx(1'b1);
    mcu_u.set_fault_low(1'b0);
    wait_mode(ltc_pkg::LTC_OPERATION, 30, "command released");
  endtask

  task automatic t_thermal;
    mcu_u.set_tx(1'b0);
    settle(10);
    hot = 1'b1;
    settle(10);
    chk_bit(bus_oe, 1'b0, "thermal driver off");
    chk_bit(f_oe, 1'b1, "thermal fault");
    mcu_u.set_tx(1'b1);
    settle(10);
    chk_bit(reg_on, 1'b0, "thermal regulator off");
    hot = 1'b0;
    wait_mode(ltc_pkg::LTC_OPERATION, 300, "cooled");
    chk_bit(reg_on, 1'b1, "regulator after cooling");
  endtask

  // Regulator out of range, then collapsed below threshold, then recovered
  task automatic t_vreg;
    mcu_u.set_tx(1'b0);
    settle(10);
    vreg_ok = 1'b0;
    settle(10);
    chk_bit(f_oe, 1'b1, "supply fault");
    chk_bit(bus_oe, 1'b0, "driver off supply");
    chk_bit(r_oe, 1'b1, "reset out on supply");
    vreg_min = 1'b0;
    settle(10);
    chk_bit(bus_oe, 1'b0, "data forced high");
    chk_bit(reg_on, 1'b0, "overload off");
    vreg_min = 1'b1;
    vreg_ok = 1'b1;
    for (int i = 0; i < 120 && reg_on !== 1'b1; i++) @(negedge clk);
    chk_bit(reg_on, 1'b1, "overload retry");
    // Battery sag turns the regulator off; the overload retry must not revive it
    vbb_ok = 1'b0;
    vreg_min = 1'b0;
    settle(10);
    chk_bit(reg_on, 1'b0, "low battery off");
    settle(80);
    chk_bit(reg_on, 1'b0, "off until battery back");
    vbb_ok = 1'b1;
    vreg_min = 1'b1;
    for (int i = 0; i < 20 && reg_on !== 1'b1; i++) @(negedge clk);
    chk_bit(reg_on, 1'b1, "battery restart");
    mcu_u.set_tx(1'b1);
    wait_mode(ltc_pkg::LTC_OPERATION, 300, "supply back");
    settle(30);
    chk_bit(r_oe, 1'b0, "reset out released again");
  endtask

  // Power-Down, bus wake to Ready, then select wake into tx off via fault low
  task automatic t_power_down;
    mcu_u.set_sel(1'b1, 1'b0);
    wait_mode(ltc_pkg::LTC_POWER_DOWN, 30, "select low");
    chk_bit(r_oe, 1'b1, "reset out in power down");
    settle(3);
    chk_bit(reg_on, 1'b0, "regulator off power down");
    ext_dom = 1'b1;
    wait_mode(ltc_pkg::LTC_READY, 30, "bus edge wake");
    ext_dom = 1'b0;
    mcu_u.set_sel(1'b1, 1'b1);
    wait_mode(ltc_pkg::LTC_OPERATION, 60, "ready to op");
    mcu_u.set_sel(1'b1, 1'b0);
    wait_mode(ltc_pkg::LTC_POWER_DOWN, 30, "op to pd");
    mcu_u.set_fault_low(1'b1);
    mcu_u.set_sel(1'b1, 1'b1);
    wait_mode(ltc_pkg::LTC_TRANSMITTER_OFF_MODE, 300, "wake to tx off");
    mcu_u.set_sel(1'b1, 1'b0);
    wait_mode(ltc_pkg::LTC_POWER_DOWN, 30, "tx off to pd");
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    t_reset();
    t_ready();
    t_wake();
    t_drive();
    t_mismatch();
    t_ext_off();
    t_thermal();
    t_vreg();
    t_power_down();
    close_out();
  end
endmodule
`default_nettype wire
